// ==== design/atpwm_axil_slave.v ====
`timescale 1ns/100ps
// **********************************************************
// axi4-lite slave front end: one write and one read at a time
// **********************************************************
`include "atpwm_defines.vh"
module atpwm_axil_slave (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // write address channel
  input wire [7:0] s_axil_awaddr,
  input wire s_axil_awvalid,
  output wire s_axil_awready,
  // write data channel
  input wire [31:0] s_axil_wdata,
  input wire [3:0] s_axil_wstrb,
  input wire s_axil_wvalid,
  output wire s_axil_wready,
  // write response channel
  output reg [1:0] s_axil_bresp,
  output reg s_axil_bvalid,
  input wire s_axil_bready,
  // read address channel
  input wire [7:0] s_axil_araddr,
  input wire s_axil_arvalid,
  output wire s_axil_arready,
  // read data channel
  output reg [31:0] s_axil_rdata,
  output reg [1:0] s_axil_rresp,
  output reg s_axil_rvalid,
  input wire s_axil_rready,
  // register file side
  output wire wrEn,
  output wire [5:0] wrIdx,
  output wire [7:0] wrData,
  input wire wrHit,
  output wire rdEn,
  output wire [5:0] rdIdx,
  input wire [7:0] rdData,
  input wire rdHit
);
  reg awHeld_r;
  reg wHeld_r;
  reg [7:0] awAddr_r;
  reg [7:0] wData_r;
  reg wLane0_r;

  assign s_axil_awready = !awHeld_r && !s_axil_bvalid;
  assign s_axil_wready = !wHeld_r && !s_axil_bvalid;
  assign s_axil_arready = !s_axil_rvalid;

  // only byte lane 0 carries register data; a write without it changes nothing
  assign wrEn = awHeld_r && wHeld_r && wLane0_r;
  assign wrIdx = awAddr_r[7:2];
  assign wrData = wData_r;
  assign rdEn = s_axil_arvalid && s_axil_arready;
  assign rdIdx = s_axil_araddr[7:2];

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      awHeld_r <= 1'b0;
      wHeld_r <= 1'b0;
      awAddr_r <= 8'h00;
      wData_r <= 8'h00;
      wLane0_r <= 1'b0;
      s_axil_bresp <= `ATPWM_RESP_OKAY;
      s_axil_bvalid <= 1'b0;
      s_axil_rdata <= 32'h0000_0000;
      s_axil_rresp <= `ATPWM_RESP_OKAY;
      s_axil_rvalid <= 1'b0;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        awHeld_r <= 1'b1;
        awAddr_r <= s_axil_awaddr;
      end
      if (s_axil_wvalid && s_axil_wready) begin
        wHeld_r <= 1'b1;
        wData_r <= s_axil_wdata[7:0];
        wLane0_r <= s_axil_wstrb[0];
      end
      if (awHeld_r && wHeld_r) begin
        awHeld_r <= 1'b0;
        wHeld_r <= 1'b0;
        s_axil_bvalid <= 1'b1;
        s_axil_bresp <= wrHit ? `ATPWM_RESP_OKAY : `ATPWM_RESP_SLVERR;
      end else if (s_axil_bvalid && s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
      if (rdEn) begin
        s_axil_rvalid <= 1'b1;
        s_axil_rdata <= {24'h00_0000, rdData};
        s_axil_rresp <= rdHit ? `ATPWM_RESP_OKAY : `ATPWM_RESP_SLVERR;
      end else if (s_axil_rvalid && s_axil_rready) begin
        s_axil_rvalid <= 1'b0;
      end
    end
  end
endmodule

// ==== design/atpwm_defines.vh ====
`ifndef ATPWM_DEFINES_VH
`define ATPWM_DEFINES_VH

// register indices; byte address is four times the index
`define ATPWM_IDX_TIMER_CTRL_STATUS 6'h0d
`define ATPWM_IDX_COUNT_HIGH 6'h0e
`define ATPWM_IDX_COUNT_LOW 6'h0f
`define ATPWM_IDX_RELOAD_HIGH 6'h10
`define ATPWM_IDX_RELOAD_LOW 6'h11
`define ATPWM_IDX_WAVE_OUT_CTRL 6'h12
`define ATPWM_IDX_WAVE_CTRL_STATUS 6'h13
`define ATPWM_IDX_DUTY_HIGH 6'h17
`define ATPWM_IDX_DUTY_LOW 6'h18

// timer_control_status fields
`define ATPWM_SRC_HI 4
`define ATPWM_SRC_LO 3
`define ATPWM_WRAP_FLAG_BIT 2
`define ATPWM_WRAP_IE_BIT 1
`define ATPWM_MATCH_IE_BIT 0

// wave_control_status and wave_output_control fields
`define ATPWM_POLARITY_BIT 1
`define ATPWM_MATCH_FLAG_BIT 0
`define ATPWM_OUT_EN_BIT 0

// counter source codes
`define ATPWM_SRC_OFF 2'h0
`define ATPWM_SRC_LITE 2'h1
`define ATPWM_SRC_CPU 2'h2

// reset values and counter limits
`define ATPWM_RST_BYTE 8'h00
`define ATPWM_RST_WORD12 12'h000
`define ATPWM_CNT_MAX 12'hfff

// bus answers
`define ATPWM_RESP_OKAY 2'h0
`define ATPWM_RESP_SLVERR 2'h2

`endif

// ==== design/atpwm_tick_sync.v ====
`timescale 1ns/100ps
// **********************************************************
// lite timebase tick: three-flop synchroniser, rising-edge pulse
// **********************************************************
module atpwm_tick_sync (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // asynchronous level in, one-cycle pulse out
  input wire levelIn,
  output wire tickPulse
);
  reg sync1_r;
  reg sync2_r;
  reg sync3_r;
  reg level_r;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
      sync3_r <= 1'b0;
      level_r <= 1'b0;
    end else begin
      sync1_r <= levelIn;
      sync2_r <= sync1_r;
      sync3_r <= sync2_r;
      // a change counts only once the second and third stages agree
      if (sync2_r == sync3_r) begin
        level_r <= sync3_r;
      end
    end
  end

  assign tickPulse = (sync2_r == sync3_r) && sync3_r && !level_r;
endmodule

// ==== design/atpwm_timer.v ====
// The AXI4-Lite interface to the registers was left to the implementer.
`timescale 1ns/100ps
// Function
// [R01] two-bit source: 00 off, 01 lite tick, 10 cpu clock, 11 reserved
// [R02] 12-bit counter, reset to zero, counts up on each selected tick
// [R03] on overflow the counter reloads from the reload value
// [R04] wrap flag set on FFF-to-reload transition, cleared by status read
// [R05] cleared wrap flag still reads high for one more counter tick
// [R06] wrap interrupt enable gates wrap flag onto its request
// [R07] match interrupt enable gates match flag onto its request
// [R08] software reads counter low byte first, beware low byte near FF
// [R09] 12-bit reload value in high/low bytes, writable, reset to zero
// [R10] software writes duty high byte before duty low byte
// [R11] output enable picks pulse-width duty or output-compare use of duty value
// [R12] polarity bit 1 gives non-inverted waveform, 0 inverts it
// [R13] match flag set when counter equals compare value, cleared by read; here a zero compare value never sets it
// [R14] output enable 0 frees the pin, 1 drives the waveform
// [R15] reserved bits read back as zero
// [R16] each overflow loads the shadow duty and drives the wave high
// [R17] duty match drives the wave low until the next overflow
// [R18] duty high write stops compare until duty low is written
// [R19] in compare mode a written duty value acts immediately
// [R20] reserved source code holds the counter, no events
// [R21] an event in the same cycle as a clearing read keeps the flag set
`include "atpwm_defines.vh"
module atpwm_timer (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // lite timer timebase, asynchronous level
  input wire liteTimebaseTick,
  // axi4-lite write address
  input wire [7:0] s_axil_awaddr,
  input wire s_axil_awvalid,
  output wire s_axil_awready,
  // axi4-lite write data
  input wire [31:0] s_axil_wdata,
  input wire [3:0] s_axil_wstrb,
  input wire s_axil_wvalid,
  output wire s_axil_wready,
  // axi4-lite write response
  output wire [1:0] s_axil_bresp,
  output wire s_axil_bvalid,
  input wire s_axil_bready,
  // axi4-lite read address
  input wire [7:0] s_axil_araddr,
  input wire s_axil_arvalid,
  output wire s_axil_arready,
  // axi4-lite read data
  output wire [31:0] s_axil_rdata,
  output wire [1:0] s_axil_rresp,
  output wire s_axil_rvalid,
  input wire s_axil_rready,
  // wave pin
  output wire wavePinOut,
  output wire wavePinOe,
  // interrupt requests
  output wire wrapIrq,
  output wire matchIrq
);
  // **********************************************************
  // bus front end
  // **********************************************************
  wire wrEn;
  wire [5:0] wrIdx;
  wire [7:0] wrData;
  wire rdEn;
  wire [5:0] rdIdx;
  reg [7:0] rdData;
  wire liteTickPulse;

  function isMapped;
    input [5:0] idx;
    begin
      isMapped = (idx >= `ATPWM_IDX_TIMER_CTRL_STATUS && idx <= `ATPWM_IDX_WAVE_CTRL_STATUS)
        || idx == `ATPWM_IDX_DUTY_HIGH || idx == `ATPWM_IDX_DUTY_LOW;
    end
  endfunction

  atpwm_axil_slave atpwm_axil_slave_inst (
    .core_clk(core_clk),
    .rst(rst),
    .s_axil_awaddr(s_axil_awaddr),
    .s_axil_awvalid(s_axil_awvalid),
    .s_axil_awready(s_axil_awready),
    .s_axil_wdata(s_axil_wdata),
    .s_axil_wstrb(s_axil_wstrb),
    .s_axil_wvalid(s_axil_wvalid),
    .s_axil_wready(s_axil_wready),
    .s_axil_bresp(s_axil_bresp),
    .s_axil_bvalid(s_axil_bvalid),
    .s_axil_bready(s_axil_bready),
    .s_axil_araddr(s_axil_araddr),
    .s_axil_arvalid(s_axil_arvalid),
    .s_axil_arready(s_axil_arready),
    .s_axil_rdata(s_axil_rdata),
    .s_axil_rresp(s_axil_rresp),
    .s_axil_rvalid(s_axil_rvalid),
    .s_axil_rready(s_axil_rready),
    .wrEn(wrEn),
    .wrIdx(wrIdx),
    .wrData(wrData),
    .wrHit(isMapped(wrIdx)),
    .rdEn(rdEn),
    .rdIdx(rdIdx),
    .rdData(rdData),
    .rdHit(isMapped(rdIdx))
  );

  atpwm_tick_sync atpwm_tick_sync_inst (
    .core_clk(core_clk),
    .rst(rst),
    .levelIn(liteTimebaseTick),
    .tickPulse(liteTickPulse)
  );

  // **********************************************************
  // software registers
  // **********************************************************
  reg [1:0] counterSourceSel_r;
  reg wrapIrqEnable_r;
  reg matchIrqEnable_r;
  reg [11:0] reloadValue_r;
  reg waveOutEnable_r;
  reg outputPolarity_r;
  reg [11:0] dutyValue_r;
  reg compareArmed_r;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      counterSourceSel_r <= 2'h0; // R01
      wrapIrqEnable_r <= 1'b0;
      matchIrqEnable_r <= 1'b0;
      reloadValue_r <= `ATPWM_RST_WORD12; // R09
      waveOutEnable_r <= 1'b0;
      outputPolarity_r <= 1'b0;
      dutyValue_r <= `ATPWM_RST_WORD12;
      compareArmed_r <= 1'b1;
    end else if (wrEn) begin
      case (wrIdx)
        `ATPWM_IDX_TIMER_CTRL_STATUS: begin
          counterSourceSel_r <= wrData[`ATPWM_SRC_HI:`ATPWM_SRC_LO]; // R01
          wrapIrqEnable_r <= wrData[`ATPWM_WRAP_IE_BIT]; // R06
          matchIrqEnable_r <= wrData[`ATPWM_MATCH_IE_BIT]; // R07
        end
        `ATPWM_IDX_RELOAD_HIGH: begin
          reloadValue_r[11:8] <= wrData[3:0]; // R09
        end
        `ATPWM_IDX_RELOAD_LOW: begin
          reloadValue_r[7:0] <= wrData; // R09
        end
        `ATPWM_IDX_WAVE_OUT_CTRL: begin
          waveOutEnable_r <= wrData[`ATPWM_OUT_EN_BIT]; // R14
        end
        `ATPWM_IDX_WAVE_CTRL_STATUS: begin
          outputPolarity_r <= wrData[`ATPWM_POLARITY_BIT]; // R12
        end
        `ATPWM_IDX_DUTY_HIGH: begin
          dutyValue_r[11:8] <= wrData[3:0];
          compareArmed_r <= 1'b0; // R18
        end
        `ATPWM_IDX_DUTY_LOW: begin
          dutyValue_r[7:0] <= wrData;
          compareArmed_r <= 1'b1; // R18
        end
        default: begin
        end
      endcase
    end
  end

  // **********************************************************
  // counter, shadow duty and events
  // **********************************************************
  reg [11:0] counterValue_r;
  reg [11:0] dutyShadow_r;
  reg waveRaw_r;
  reg counterTick;
  wire wrapEvent;
  wire [11:0] compareValue;
  wire matchEvent;

  always @* begin
    case (counterSourceSel_r)
      `ATPWM_SRC_LITE: counterTick = liteTickPulse; // R01
      `ATPWM_SRC_CPU: counterTick = 1'b1; // R01
      default: counterTick = 1'b0; // R20
    endcase
  end

  assign wrapEvent = counterTick && (counterValue_r == `ATPWM_CNT_MAX); // R04
  // compare mode sees the written value at once; wave mode uses the shadow
  assign compareValue = waveOutEnable_r ? dutyShadow_r : dutyValue_r; // R11 R19
  // zero is the reset value and never compares
  assign matchEvent = counterTick && compareArmed_r && (compareValue != `ATPWM_RST_WORD12)
    && (counterValue_r == compareValue); // R13

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      counterValue_r <= `ATPWM_RST_WORD12; // R02
      dutyShadow_r <= `ATPWM_RST_WORD12;
      waveRaw_r <= 1'b0;
    end else begin
      if (wrapEvent) begin
        counterValue_r <= reloadValue_r; // R03
        // a half-written duty value still moves over here, as the shadow is blind
        dutyShadow_r <= dutyValue_r; // R16
        waveRaw_r <= 1'b1; // R16
      end else if (counterTick) begin
        counterValue_r <= counterValue_r + 12'h001; // R02
      end
      if (matchEvent && waveOutEnable_r && !wrapEvent) begin
        waveRaw_r <= 1'b0; // R17
      end
    end
  end

  // **********************************************************
  // flags
  // **********************************************************
  reg wrapFlag_r;
  reg wrapClrPending_r;
  reg matchFlag_r;
  wire wrapStatusRead;
  wire matchStatusRead;

  assign wrapStatusRead = rdEn && (rdIdx == `ATPWM_IDX_TIMER_CTRL_STATUS);
  assign matchStatusRead = rdEn && (rdIdx == `ATPWM_IDX_WAVE_CTRL_STATUS);

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wrapFlag_r <= 1'b0;
      wrapClrPending_r <= 1'b0;
      matchFlag_r <= 1'b0;
    end else begin
      if (wrapEvent) begin
        wrapFlag_r <= 1'b1; // R04 R21
        wrapClrPending_r <= 1'b0; // R21
      end else if (wrapClrPending_r && counterTick) begin
        // flag lingers one counter tick after the read, then drops
        wrapFlag_r <= 1'b0; // R05
        wrapClrPending_r <= 1'b0;
      end else if (wrapStatusRead && wrapFlag_r) begin
        wrapClrPending_r <= 1'b1; // R04 R05
      end
      if (matchEvent) begin
        matchFlag_r <= 1'b1; // R13 R21
      end else if (matchStatusRead && matchFlag_r) begin
        matchFlag_r <= 1'b0; // R13 R21
      end
    end
  end

  assign wrapIrq = wrapFlag_r && wrapIrqEnable_r; // R06
  assign matchIrq = matchFlag_r && matchIrqEnable_r; // R07

  // **********************************************************
  // read mux
  // **********************************************************
  always @* begin
    rdData = `ATPWM_RST_BYTE; // R15
    case (rdIdx)
      `ATPWM_IDX_TIMER_CTRL_STATUS: begin
        rdData = {3'b000, counterSourceSel_r, wrapFlag_r, wrapIrqEnable_r,
          matchIrqEnable_r};
      end
      `ATPWM_IDX_COUNT_HIGH: begin
        // no latch between halves; software reads the low byte first
        rdData = {4'h0, counterValue_r[11:8]}; // R08
      end
      `ATPWM_IDX_COUNT_LOW: begin
        rdData = counterValue_r[7:0];
      end
      `ATPWM_IDX_RELOAD_HIGH: begin
        rdData = {4'h0, reloadValue_r[11:8]}; // R15
      end
      `ATPWM_IDX_RELOAD_LOW: begin
        rdData = reloadValue_r[7:0];
      end
      `ATPWM_IDX_WAVE_OUT_CTRL: begin
        rdData = {7'h00, waveOutEnable_r};
      end
      `ATPWM_IDX_WAVE_CTRL_STATUS: begin
        rdData = {6'h00, outputPolarity_r, matchFlag_r};
      end
      `ATPWM_IDX_DUTY_HIGH: begin
        // high byte is written first, low byte arms compare
        rdData = {4'h0, dutyValue_r[11:8]}; // R10
      end
      `ATPWM_IDX_DUTY_LOW: begin
        rdData = dutyValue_r[7:0];
      end
      default: begin
        rdData = `ATPWM_RST_BYTE;
      end
    endcase
  end

  // **********************************************************
  // pin drive
  // **********************************************************
  reg wavePinOut_r;
  reg wavePinOe_r;

  always @(posedge core_clk or posedge rst) begin
    if (rst) begin
      wavePinOut_r <= 1'b0;
      wavePinOe_r <= 1'b0;
    end else begin
      // no waveform in compare mode; the pin is released to gpio
      wavePinOut_r <= waveOutEnable_r && (waveRaw_r ^ !outputPolarity_r); // R12
      wavePinOe_r <= waveOutEnable_r; // R14
    end
  end

  assign wavePinOut = wavePinOut_r;
  assign wavePinOe = wavePinOe_r;
endmodule

// ==== test/atpwm_timer_assertions.sv ====
`timescale 1ns/100ps
`include "atpwm_defines.vh"
// ****************************************
// port checker for the timer top
// ****************************************
module atpwm_timer_assertions (
  // clock and reset
  input wire core_clk,
  input wire rst,
  // timebase
  input wire liteTimebaseTick,
  // write side
  input wire [7:0] s_axil_awaddr,
  input wire s_axil_awvalid,
  input wire s_axil_awready,
  input wire [31:0] s_axil_wdata,
  input wire [3:0] s_axil_wstrb,
  input wire s_axil_wvalid,
  input wire s_axil_wready,
  input wire [1:0] s_axil_bresp,
  input wire s_axil_bvalid,
  input wire s_axil_bready,
  // read side
  input wire [7:0] s_axil_araddr,
  input wire s_axil_arvalid,
  input wire s_axil_arready,
  input wire [31:0] s_axil_rdata,
  input wire [1:0] s_axil_rresp,
  input wire s_axil_rvalid,
  input wire s_axil_rready,
  // pin and requests
  input wire wavePinOut,
  input wire wavePinOe,
  input wire wrapIrq,
  input wire matchIrq
);
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  AST_PIN_FREE: assert property (!wavePinOe |-> !wavePinOut)
    else $error("pin level while released");
  AST_RD_ANSWER: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
    else $error("read answer late");
  AST_RD_HOLD: assert property (s_axil_rvalid && !s_axil_rready
    |=> s_axil_rvalid && $stable(s_axil_rdata))
    else $error("read data dropped early");
  AST_AR_BLOCK: assert property (s_axil_rvalid |-> !s_axil_arready)
    else $error("second read taken");
  AST_RD_RSV: assert property (s_axil_rvalid |-> s_axil_rdata[31:8] == 24'h00_0000)
    else $error("upper read bits set");
  AST_WR_ANSWER: assert property (s_axil_awvalid && s_axil_awready && s_axil_wvalid
    && s_axil_wready |=> !s_axil_bvalid ##1 s_axil_bvalid)
    else $error("write answer timing");
  AST_B_HOLD: assert property (s_axil_bvalid && !s_axil_bready
    |=> s_axil_bvalid && $stable(s_axil_bresp))
    else $error("write answer dropped early");
  AST_RESP_CODE: assert property (s_axil_rvalid |-> s_axil_rresp == `ATPWM_RESP_OKAY
    || s_axil_rresp == `ATPWM_RESP_SLVERR)
    else $error("odd read code");
endmodule
bind atpwm_timer atpwm_timer_assertions atpwm_timer_assertions_inst (.*);

// ==== test/atpwm_timer_test.sv ====
`timescale 1ns/100ps
`include "atpwm_defines.vh"
module atpwm_timer_test;
  reg core_clk = 0;
  reg rst = 1;
  reg liteTimebaseTick = 0;
  reg [7:0] s_axil_awaddr = 8'h00;
  reg s_axil_awvalid = 0;
  reg [31:0] s_axil_wdata = 32'h0000_0000;
  reg [3:0] s_axil_wstrb = 4'hf;
  reg s_axil_wvalid = 0;
  reg s_axil_bready = 0;
  reg [7:0] s_axil_araddr = 8'h00;
  reg s_axil_arvalid = 0;
  reg s_axil_rready = 0;
  wire s_axil_awready, s_axil_wready, s_axil_bvalid, s_axil_arready, s_axil_rvalid;
  wire [1:0] s_axil_bresp, s_axil_rresp;
  wire [31:0] s_axil_rdata;
  wire wavePinOut, wavePinOe, wrapIrq, matchIrq;
  integer fail_count = 0;
  integer checks = 0;
  reg [7:0] rv;
  reg [1:0] rs;
  reg [7:0] lo;
  integer hi;
  atpwm_timer atpwm_timer_inst (.*);
  initial forever #2.5 core_clk = ~core_clk;
  // ****************************************
  // reporting
  // ****************************************
  task stop_test;
    begin
      $display("checks %0d mismatches %0d", checks, fail_count);
      if (fail_count == 0 && checks > 0)
        $display("Regression OK");
      else
        $display("Regression broken");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [31:0] e, input [31:0] g);
    begin
      checks = checks + 1;
      if (g !== e) begin
        fail_count = fail_count + 1;
        $display("BAD %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task tmo;
    begin
      chk("timeout", 0, 1);
      stop_test;
    end
  endtask
  // ****************************************
  // bus master: holds each channel until taken
  // ****************************************
  task wr(input [5:0] i, input [7:0] d);
    integer n;
    begin
      n = 0;
      @(posedge core_clk);
      s_axil_awaddr <= {i, 2'b00};
      s_axil_wdata <= {24'h00_0000, d};
      s_axil_awvalid <= 1;
      s_axil_wvalid <= 1;
      s_axil_bready <= 1;
      do begin
        @(posedge core_clk);
        if (s_axil_awready) s_axil_awvalid <= 0;
        if (s_axil_wready) s_axil_wvalid <= 0;
        if (s_axil_bvalid) begin
          s_axil_bready <= 0;
          rs = s_axil_bresp;
        end
        n = n + 1;
        if (n > 50) tmo;
      end while (s_axil_bready);
    end
  endtask
  task rd(input [5:0] i);
    integer n;
    begin
      n = 0;
      @(posedge core_clk);
      s_axil_araddr <= {i, 2'b00};
      s_axil_arvalid <= 1;
      s_axil_rready <= 1;
      do begin
        @(posedge core_clk);
        if (s_axil_arready) s_axil_arvalid <= 0;
        if (s_axil_rvalid) begin
          s_axil_rready <= 0;
          rv = s_axil_rdata[7:0];
          rs = s_axil_rresp;
        end
        n = n + 1;
        if (n > 50) tmo;
      end while (s_axil_rready);
    end
  endtask
  task rc(input [63:0] nm, input [5:0] i, input [7:0] e);
    begin
      rd(i);
      chk(nm, e, rv);
    end
  endtask
  // high cycles of the pin over two 16-count periods
  task meas;
    integer n;
    begin
      hi = 0;
      repeat (4) @(posedge core_clk);
      for (n = 0; n < 32; n = n + 1) begin
        @(posedge core_clk);
        hi = hi + wavePinOut;
      end
    end
  endtask
  // ****************************************
  // scenarios
  // ****************************************
  task resetValues;
    integer i;
    begin
      for (i = `ATPWM_IDX_TIMER_CTRL_STATUS; i <= `ATPWM_IDX_DUTY_LOW; i = i + 1) begin
        rc("rstval", i, 8'h00);
        chk("rresp", (i > `ATPWM_IDX_WAVE_CTRL_STATUS && i < `ATPWM_IDX_DUTY_HIGH) ?
          `ATPWM_RESP_SLVERR : `ATPWM_RESP_OKAY, rs);
      end
      wr(6'h14, 8'hff);
      chk("bresp", `ATPWM_RESP_SLVERR, rs);
    end
  endtask
  task wrapRun;
    integer n;
    begin
      wr(`ATPWM_IDX_RELOAD_HIGH, 8'h0f);
      wr(`ATPWM_IDX_RELOAD_LOW, 8'hf0);
      rc("relhi", `ATPWM_IDX_RELOAD_HIGH, 8'h0f);
      wr(`ATPWM_IDX_TIMER_CTRL_STATUS, 8'h12);
      for (n = 0; wrapIrq !== 1'b1; n = n + 1) begin
        @(posedge core_clk);
        if (n > 5000) tmo;
      end
      chk("wrapcyc", 1, n > 4085 && n < 4100);
      wr(`ATPWM_IDX_TIMER_CTRL_STATUS, 8'h08);
      chk("wrapmask", 0, wrapIrq);
      rc("tcsset", `ATPWM_IDX_TIMER_CTRL_STATUS, 8'h0c);
      rc("tcshold", `ATPWM_IDX_TIMER_CTRL_STATUS, 8'h0c);
      // low byte first, so a carry between the two reads lands in the high byte
      rd(`ATPWM_IDX_COUNT_LOW);
      lo = rv;
      chk("cntlo", 4'hf, lo[7:4]);
      rc("cnthi", `ATPWM_IDX_COUNT_HIGH, 8'h0f);
      // the synchroniser needs three edges, so hold the level well past that
      liteTimebaseTick <= 1;
      repeat (8) @(posedge core_clk);
      liteTimebaseTick <= 0;
      rc("tcsclr", `ATPWM_IDX_TIMER_CTRL_STATUS, lo == 8'hff ? 8'h0c : 8'h08);
      lo = (lo == 8'hff) ? 8'hf0 : lo + 8'h01;
      rc("litecnt", `ATPWM_IDX_COUNT_LOW, lo);
      wr(`ATPWM_IDX_TIMER_CTRL_STATUS, 8'h18);
      repeat (20) @(posedge core_clk);
      rc("rsvhold", `ATPWM_IDX_COUNT_LOW, lo);
    end
  endtask
  task pwmRun;
    begin
      wr(`ATPWM_IDX_DUTY_HIGH, 8'h0f);
      wr(`ATPWM_IDX_DUTY_LOW, 8'hfc);
      wr(`ATPWM_IDX_WAVE_OUT_CTRL, 8'h01);
      wr(`ATPWM_IDX_WAVE_CTRL_STATUS, 8'h02);
      wr(`ATPWM_IDX_TIMER_CTRL_STATUS, 8'h10);
      // the counter resumes inside ff0..fff, so the first wrap that loads the shadow comes within 16 counts
      repeat (3900) @(posedge core_clk);
      meas;
      chk("pwmhigh", 26, hi);
      chk("pinoe", 1, wavePinOe);
      wr(`ATPWM_IDX_WAVE_CTRL_STATUS, 8'h00);
      meas;
      chk("pwminv", 6, hi);
      rc("pwmflag", `ATPWM_IDX_WAVE_CTRL_STATUS, 8'h01);
      wr(`ATPWM_IDX_WAVE_OUT_CTRL, 8'h00);
      meas;
      chk("pinfree", 0, hi);
      chk("pinoff", 0, wavePinOe);
    end
  endtask
  task cmpRun;
    integer n;
    begin
      wr(`ATPWM_IDX_TIMER_CTRL_STATUS, 8'h11);
      wr(`ATPWM_IDX_DUTY_HIGH, 8'h0f);
      rd(`ATPWM_IDX_WAVE_CTRL_STATUS);
      repeat (40) @(posedge core_clk);
      chk("disarm", 0, matchIrq);
      rc("wcsoff", `ATPWM_IDX_WAVE_CTRL_STATUS, 8'h00);
      wr(`ATPWM_IDX_DUTY_LOW, 8'hf4);
      for (n = 0; matchIrq !== 1'b1; n = n + 1) begin
        @(posedge core_clk);
        if (n > 20) tmo;
      end
      rc("wcsset", `ATPWM_IDX_WAVE_CTRL_STATUS, 8'h01);
      wr(`ATPWM_IDX_TIMER_CTRL_STATUS, 8'h10);
      chk("cmpmask", 0, matchIrq);
    end
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    rst <= 0;
    resetValues;
    wrapRun;
    pwmRun;
    cmpRun;
    stop_test;
  end
endmodule
